// ==== rtl/mafp_regs.svh ====
// register map, field positions and timing counts of the pause/filter block
//
// Function
// - The pause time count field always reads the live pause countdown.
// - A nonzero countdown drops by one every 512 bit times of the link.
// - The low hash word holds filter bits 31:0 and reads back as written.
// - The high hash word holds filter bits 63:32 and reads back as written.
// - Each slot keeps address bits 31:0 low and bits 47:32 in top 15:0.
// - Bit zero of a stored address marks multicast versus unicast.
// - Stored bit zero maps to the lsb of the first received address byte.
// - Countdown reaching zero sets a flag that a status read clears.
// - The count field sits in bits 15:0 with bits 31:16 reading zero.
`ifndef MAFP_REGS_SVH
`define MAFP_REGS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define MAFP_STATUS_OFS 8'h00
`define MAFP_CTRL_OFS   8'h04
`define MAFP_PAUSE_OFS  8'h38
`define MAFP_HASHLO_OFS 8'h40
`define MAFP_HASHHI_OFS 8'h44
`define MAFP_SA_BASE    8'h48
`define MAFP_SA_STEP    8'h08
`define MAFP_SA_HI_OFS  8'h04

// ***************************************************************
// fields and reset values
// ***************************************************************
`define MAFP_PZF_BIT    0
`define MAFP_SPEED_BIT  0
`define MAFP_PAUSE_W    16
`define MAFP_SA_HI_W    16
`define MAFP_SLOTS      4
`define MAFP_DA_BYTES   6
`define MAFP_RST_WORD   32'h0000_0000

// ***************************************************************
// timing: one pause quantum is 512 bit times
// ***************************************************************
`define MAFP_CLK_MHZ    125
`define MAFP_QUANT_BITS 512
`define MAFP_Q100_NS    (`MAFP_QUANT_BITS * 10)
`define MAFP_Q10_NS     (`MAFP_QUANT_BITS * 100)
`define MAFP_Q100_CYC   ((`MAFP_Q100_NS * `MAFP_CLK_MHZ) / 1000)
`define MAFP_Q10_CYC    ((`MAFP_Q10_NS * `MAFP_CLK_MHZ) / 1000)

`endif

// ==== rtl/mafp_pkg.sv ====
// types shared by the pause/filter block
package mafp_pkg;

	// one received byte from the mac receive path
	typedef struct packed {
		logic       valid; // byte present this cycle
		logic       first; // first byte of a frame
		logic [7:0] data;  // byte value, lsb first on the wire
	} mafp_rxbyte_t;

	// result of a destination address check
	typedef struct packed {
		logic       checked; // one-cycle pulse: result valid
		logic       hit;     // destination equals a slot
		logic [1:0] slot;    // lowest matching slot
		logic       mcast;   // destination multicast bit
	} mafp_match_t;

endpackage : mafp_pkg

// ==== rtl/mafp_pause_timer.sv ====
// pause countdown with 512-bit-time quantum divider
`timescale 1ns/1ps
`include "mafp_regs.svh"
module mafp_pause_timer #(
	parameter int unsigned PW   = `MAFP_PAUSE_W,
	parameter int unsigned Q100 = `MAFP_Q100_CYC,
	parameter int unsigned Q10  = `MAFP_Q10_CYC
) (
	input  wire logic          clk_sys,   // system clock
	input  wire logic          reset_n,   // async reset, low
	input  wire logic          load,      // software write pulse
	input  wire logic [PW-1:0] loadValue, // value written
	input  wire logic          speed100,  // 1: 100 Mb/s link
	output logic      [PW-1:0] count,     // live countdown
	output logic               zeroEvent  // pulse on reaching zero
);
	import mafp_pkg::*;
	// divider must hold the longer of the two quanta, else one is cut short
	localparam int unsigned QMAX = (Q10 > Q100) ? Q10 : Q100;
	localparam int unsigned DW   = $clog2(QMAX + 1);

	logic [DW-1:0] div_reg;
	logic [DW-1:0] limit;
	logic          tick;

	// quantum length follows link speed
	assign limit = speed100 ? DW'(Q100 - 1) : DW'(Q10 - 1);
	assign tick  = (count != '0) && (div_reg == limit) && !load;

	// divider restarts on load so a fresh value gets a full quantum
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			div_reg <= '0;
		else if (load || count == '0 || div_reg >= limit)
			div_reg <= '0;
		else
			div_reg <= div_reg + 1'b1;

	// countdown; a write wins over a decrement
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			count <= '0;
		else if (load)
			count <= loadValue;
		else if (tick)
			count <= count - 1'b1;

	// zero reached by counting, not by a write of zero
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			zeroEvent <= 1'b0;
		else
			zeroEvent <= tick && (count == PW'(1));

	a_tick_decrement: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		tick |=> count == $past(count) - 1'b1)
		else $error("pause count missed a decrement");
	a_quantum_hold: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(count != '0 && div_reg == '0 && !load && speed100) ##1 !load [*8]
		|-> $stable(count))
		else $error("pause count moved inside a quantum");
	a_zero_event: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		zeroEvent |-> count == '0 && $past(count) == PW'(1))
		else $error("zero event without reaching zero");
	c_zero_reached: cover property (@(posedge clk_sys) disable iff (!reset_n)
		zeroEvent);

endmodule : mafp_pause_timer

// ==== rtl/mafp_addr_match.sv ====
// collects the destination address and compares it with four slots
`timescale 1ns/1ps
`include "mafp_regs.svh"
module mafp_addr_match (
	input  wire logic                  clk_sys,  // system clock
	input  wire logic                  reset_n,  // async reset, low
	input  wire mafp_pkg::mafp_rxbyte_t rxIn,    // received bytes
	input  wire logic [3:0][47:0]      slotAddr, // stored addresses
	output mafp_pkg::mafp_match_t      result    // check result
);
	import mafp_pkg::*;

	logic [47:0] da_reg;
	logic [2:0]  idx_reg;
	logic        pend_reg;
	logic [3:0]  hits;

	// per-slot full 48-bit equality
	function automatic logic [3:0] slotHits(input logic [47:0] da,
		input logic [3:0][47:0] sa);
		logic [3:0] h;
		h = '0;
		for (int i = 0; i < `MAFP_SLOTS; i++)
			h[i] = (da == sa[i]);
		return h;
	endfunction : slotHits

	assign hits = slotHits(da_reg, slotAddr);

	// first byte lands in bits 7:0, so its lsb is address bit zero
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			da_reg  <= '0;
			idx_reg <= '0;
		end
		else if (rxIn.valid && rxIn.first)
		begin
			da_reg[7:0] <= rxIn.data;
			idx_reg     <= 3'h1;
		end
		else if (rxIn.valid && idx_reg != 3'h0 &&
			idx_reg < 3'(`MAFP_DA_BYTES))
		begin
			da_reg[8*idx_reg +: 8] <= rxIn.data;
			idx_reg                <= idx_reg + 3'h1;
		end

	// compare one cycle after the sixth byte is stored
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			pend_reg <= 1'b0;
		else
			pend_reg <= rxIn.valid && !rxIn.first &&
				idx_reg == 3'(`MAFP_DA_BYTES - 1);

	// lowest slot wins when several hold the same address
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			result <= '0;
		else
		begin
			result.checked <= pend_reg;
			result.hit     <= pend_reg && (hits != 4'h0);
			result.slot    <= hits[0] ? 2'd0 : hits[1] ? 2'd1 :
				hits[2] ? 2'd2 : 2'd3;
			result.mcast   <= da_reg[0];
		end

	a_first_lsb: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		rxIn.valid && rxIn.first |=> da_reg[0] == $past(rxIn.data[0]))
		else $error("first byte lsb not at address bit zero");
	a_hit_equal: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		result.checked && result.hit |->
		(result.slot != 2'h0 || $past(slotAddr[0] == da_reg)) &&
		(result.slot != 2'h1 || $past(slotAddr[1] == da_reg)) &&
		(result.slot != 2'h2 || $past(slotAddr[2] == da_reg)) &&
		(result.slot != 2'h3 || $past(slotAddr[3] == da_reg)))
		else $error("hit reported on unequal slot");
	a_miss_none: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		result.checked && !result.hit |->
		$past(da_reg != slotAddr[0] && da_reg != slotAddr[1] &&
		da_reg != slotAddr[2] && da_reg != slotAddr[3]))
		else $error("equal slot not reported");
	a_mcast_bit: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		result.checked |-> result.mcast == $past(da_reg[0]))
		else $error("multicast flag not from bit zero");
	c_addr_hit: cover property (@(posedge clk_sys) disable iff (!reset_n)
		result.checked && result.hit);
	c_addr_miss: cover property (@(posedge clk_sys) disable iff (!reset_n)
		result.checked && !result.hit);

endmodule : mafp_addr_match

// ==== rtl/mafp_top.sv ====
// pause timer and destination filter registers of the mac
`timescale 1ns/1ps
`include "mafp_regs.svh"
module mafp_top #(
	parameter int unsigned Q10_CYC = `MAFP_Q10_CYC
) (
	input  wire logic                  clk_sys,    // system clock
	input  wire logic                  reset_n,    // async reset, low
	input  wire logic [7:0]            regAddr,    // byte address
	input  wire logic [31:0]           regWdata,   // write data
	input  wire logic                  regWrite,   // write strobe
	input  wire logic                  regRead,    // read strobe
	output logic      [31:0]           regRdata,   // read data, +1 cycle
	input  wire mafp_pkg::mafp_rxbyte_t rxIn,      // received bytes
	output mafp_pkg::mafp_match_t      matchOut,   // address result
	output logic      [63:0]           hashFilter, // hash filter bits
	output logic                       pauseActive // countdown nonzero
);
	import mafp_pkg::*;

	// ***************************************************************
	// storage
	// ***************************************************************
	logic [31:0]      hashLo_reg;
	logic [31:0]      hashHi_reg;
	logic [3:0][31:0] slotLo_reg;
	logic [3:0][15:0] slotHi_reg;
	logic [3:0][47:0] slotAddr;
	logic             speed_reg;
	logic             pauseZeroFlag_reg;
	logic [31:0]      rdNext;
	logic [15:0]      pauseCount;
	logic             pauseZeroEvt;
	logic             pauseLoad;
	logic             statusRead;

	// full address decode for strobes
	function automatic logic hitOfs(input logic [7:0] a,
		input logic [7:0] ofs);
		return a == ofs;
	endfunction : hitOfs

	function automatic logic [7:0] slotOfs(input int i, input logic hi);
		return 8'(`MAFP_SA_BASE + `MAFP_SA_STEP * i) |
			(hi ? `MAFP_SA_HI_OFS : 8'h00);
	endfunction : slotOfs

	// strobes of the two registers whose access has side effects
	assign pauseLoad  = regWrite && hitOfs(regAddr, `MAFP_PAUSE_OFS);
	assign statusRead = regRead && hitOfs(regAddr, `MAFP_STATUS_OFS);

	// ***************************************************************
	// pause countdown
	// ***************************************************************
	// countdown and its quantum divider live in their own module
	mafp_pause_timer #(
		.PW   (`MAFP_PAUSE_W),
		.Q100 (`MAFP_Q100_CYC),
		.Q10  (Q10_CYC)
	) u_pause (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.load      (pauseLoad),
		.loadValue (regWdata[15:0]),
		.speed100  (speed_reg),
		.count     (pauseCount),
		.zeroEvent (pauseZeroEvt)
	);

	// ***************************************************************
	// software writes
	// ***************************************************************
	// link speed picks the quantum length
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			speed_reg <= 1'b0;
		else if (regWrite && hitOfs(regAddr, `MAFP_CTRL_OFS))
			speed_reg <= regWdata[`MAFP_SPEED_BIT];

	// hash filter words
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			hashLo_reg <= `MAFP_RST_WORD;
			hashHi_reg <= `MAFP_RST_WORD;
		end
		else if (regWrite)
		begin
			if (hitOfs(regAddr, `MAFP_HASHLO_OFS))
				hashLo_reg <= regWdata;
			if (hitOfs(regAddr, `MAFP_HASHHI_OFS))
				hashHi_reg <= regWdata;
		end

	// specific address slots; top word keeps only 16 bits
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			slotLo_reg <= '0;
			slotHi_reg <= '0;
		end
		else if (regWrite)
		begin
			for (int i = 0; i < `MAFP_SLOTS; i++)
			begin
				if (hitOfs(regAddr, slotOfs(i, 1'b0)))
					slotLo_reg[i] <= regWdata;
				if (hitOfs(regAddr, slotOfs(i, 1'b1)))
					slotHi_reg[i] <= regWdata[15:0];
			end
		end

	// bit 0 of the bottom word is the group bit of the address
	always_comb
	begin
		for (int i = 0; i < `MAFP_SLOTS; i++)
			slotAddr[i] = {slotHi_reg[i], slotLo_reg[i]};
	end

	// ***************************************************************
	// status flag
	// ***************************************************************
	// a zero event in the reading cycle survives the clear
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			pauseZeroFlag_reg <= 1'b0;
		else if (pauseZeroEvt)
			pauseZeroFlag_reg <= 1'b1;
		else if (statusRead)
			pauseZeroFlag_reg <= 1'b0;

	// ***************************************************************
	// read path
	// ***************************************************************
	// unmapped offsets read zero, reserved bits read zero
	always_comb
	begin
		rdNext = `MAFP_RST_WORD;
		case (regAddr)
			`MAFP_STATUS_OFS:
				rdNext[`MAFP_PZF_BIT] = pauseZeroFlag_reg;
			`MAFP_CTRL_OFS:
				rdNext[`MAFP_SPEED_BIT] = speed_reg;
			`MAFP_PAUSE_OFS:
				rdNext[15:0] = pauseCount;
			`MAFP_HASHLO_OFS:
				rdNext = hashLo_reg;
			`MAFP_HASHHI_OFS:
				rdNext = hashHi_reg;
			default:
			begin
				for (int i = 0; i < `MAFP_SLOTS; i++)
				begin
					if (regAddr == slotOfs(i, 1'b0))
						rdNext = slotLo_reg[i];
					if (regAddr == slotOfs(i, 1'b1))
						rdNext[15:0] = slotHi_reg[i];
				end
			end
		endcase
	end

	// data stand one cycle only, zero otherwise
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			regRdata <= `MAFP_RST_WORD;
		else
			regRdata <= regRead ? rdNext : `MAFP_RST_WORD;

	// ***************************************************************
	// outputs toward the receive filter
	// ***************************************************************
	// registered copies, so every output leaves a flip-flop
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			hashFilter  <= '0;
			pauseActive <= 1'b0;
		end
		else
		begin
			hashFilter  <= {hashHi_reg, hashLo_reg};
			pauseActive <= pauseCount != '0;
		end

	// address compare runs on the live slot contents
	mafp_addr_match u_match (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.rxIn     (rxIn),
		.slotAddr (slotAddr),
		.result   (matchOut)
	);

	// ***************************************************************
	// checks: countdown
	// ***************************************************************
	a_pause_readback: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		regRead && hitOfs(regAddr, `MAFP_PAUSE_OFS)
		|=> regRdata == {16'h0000, $past(pauseCount)})
		else $error("pause read differs from live count");
	a_pause_upper: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		$past(regRead && hitOfs(regAddr, `MAFP_PAUSE_OFS))
		|-> regRdata[31:16] == 16'h0000)
		else $error("pause upper bits not zero");
	a_pause_load: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		pauseLoad
		|=> pauseCount == $past(regWdata[15:0]))
		else $error("pause write not loaded");
	a_active_track: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		pauseActive == ($past(pauseCount) != 16'h0000))
		else $error("pause active out of step with count");

	// ***************************************************************
	// checks: zero flag
	// ***************************************************************
	a_flag_set: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		pauseZeroEvt |=> pauseZeroFlag_reg)
		else $error("zero flag not set");
	a_read_clears: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		statusRead && !pauseZeroEvt |=> !pauseZeroFlag_reg
		##1 !$past(pauseZeroEvt) || pauseZeroFlag_reg)
		else $error("status read left zero flag set");
	a_flag_holds: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		pauseZeroFlag_reg && !statusRead |=> pauseZeroFlag_reg)
		else $error("zero flag dropped without a read");
	a_flag_quiet: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!pauseZeroFlag_reg && !pauseZeroEvt |=> !pauseZeroFlag_reg)
		else $error("zero flag rose without an event");
	a_status_read: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		statusRead
		|=> regRdata == {31'h0, $past(pauseZeroFlag_reg)})
		else $error("status read lost the zero flag");
	a_zero_no_load: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		pauseLoad |=> !pauseZeroEvt)
		else $error("zero event raised by a write");
	c_flag_read: cover property (@(posedge clk_sys)
		disable iff (!reset_n)
		statusRead && pauseZeroFlag_reg);
	c_set_clear: cover property (@(posedge clk_sys)
		disable iff (!reset_n)
		statusRead && pauseZeroEvt);

	// ***************************************************************
	// checks: filter words
	// ***************************************************************
	a_hash_lo_rw: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		regWrite && hitOfs(regAddr, `MAFP_HASHLO_OFS) ##1
		regRead && hitOfs(regAddr, `MAFP_HASHLO_OFS)
		|=> regRdata == $past(regWdata, 2))
		else $error("low hash word readback wrong");
	a_hash_lo_out: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		regWrite && hitOfs(regAddr, `MAFP_HASHLO_OFS)
		|=> ##1 hashFilter[31:0] == $past(regWdata, 2))
		else $error("low hash word not in filter bits");
	a_hash_hi_out: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		regWrite && hitOfs(regAddr, `MAFP_HASHHI_OFS)
		|=> ##1 hashFilter[63:32] == $past(regWdata, 2))
		else $error("high hash word not in filter bits");
	a_slot_low_first: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		regWrite && hitOfs(regAddr, slotOfs(0, 1'b0))
		|=> slotAddr[0][31:0] == $past(regWdata))
		else $error("slot bottom word misplaced");
	a_slot_low_last: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		regWrite && hitOfs(regAddr, slotOfs(3, 1'b0))
		|=> slotAddr[3][31:0] == $past(regWdata))
		else $error("last slot bottom word misplaced");
	a_slot_top: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		regWrite && hitOfs(regAddr, slotOfs(0, 1'b1))
		|=> slotAddr[0][47:32] == $past(regWdata[15:0]))
		else $error("slot top word misplaced");
	a_slot_top_last: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		regWrite && hitOfs(regAddr, slotOfs(3, 1'b1))
		|=> slotAddr[3][47:32] == $past(regWdata[15:0]))
		else $error("last slot top word misplaced");
	a_slot_lo_read: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		regRead && hitOfs(regAddr, slotOfs(2, 1'b0))
		|=> regRdata == $past(slotAddr[2][31:0]))
		else $error("slot bottom word readback wrong");
	a_slot_hi_read: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		regRead && hitOfs(regAddr, slotOfs(1, 1'b1))
		|=> regRdata == {16'h0000, $past(slotAddr[1][47:32])})
		else $error("slot top word readback wrong");

endmodule : mafp_top

// ==== testbench/mafp_link_partner.sv ====
// link partner model: delivers one destination address as received bytes
`timescale 1ns/1ps
module mafp_link_partner (
	input  wire logic                   clk_sys, // system clock
	input  wire logic                   reset_n, // async reset, low
	input  wire logic                   start,   // send one address
	input  wire logic [47:0]            dest,    // address to send
	input  wire logic [3:0]             gap,     // idle cycles per byte
	output mafp_pkg::mafp_rxbyte_t      rxOut,   // bytes to the block
	output logic                        busy     // frame in progress
);
	import mafp_pkg::*;

	// ***************************************************************
	// byte sequencer
	// ***************************************************************
	logic [2:0]  idxReg;  // next byte index
	logic [3:0]  waitReg; // idle cycles left
	logic [47:0] destReg; // captured address

	// first byte carries address bits 7:0, lsb of it is bit zero
	// idle data toggles every cycle so a stale byte can never pass
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rxOut   <= '0;
			busy    <= 1'b0;
			idxReg  <= 3'h0;
			waitReg <= 4'h0;
			destReg <= '0;
		end
		else
		begin
			rxOut.valid <= 1'b0;
			rxOut.first <= 1'b0;
			rxOut.data  <= ~rxOut.data;
			if (start && !busy)
			begin
				busy    <= 1'b1;
				idxReg  <= 3'h0;
				waitReg <= 4'h0;
				destReg <= dest;
			end
			else if (busy && waitReg != 4'h0)
				waitReg <= waitReg - 4'h1;
			else if (busy)
			begin
				rxOut.valid <= 1'b1;
				rxOut.first <= (idxReg == 3'h0);
				rxOut.data  <= destReg[8*idxReg +: 8];
				waitReg     <= gap;
				idxReg      <= idxReg + 3'h1;
				busy        <= (idxReg != 3'h5);
			end
		end
	end
endmodule : mafp_link_partner

// ==== testbench/mafp_top_test.sv ====
// self-checking bench of the pause timer and address filter registers
`timescale 1ns/1ps
`include "mafp_regs.svh"
`define CHECK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
	$display("BAD %s exp %h got %h", nm, ex, got); nErrors++; end end
module mafp_top_test;
	import mafp_pkg::*;

	// ***************************************************************
	// signals and instances
	// ***************************************************************
	localparam int unsigned Q10 = 20; // short quantum keeps run brief
	logic                   clk_sys = 1'b0;
	logic                   reset_n;
	logic [7:0]             regAddr;
	logic [31:0]            regWdata;
	logic                   regWrite;
	logic                   regRead;
	logic [31:0]            regRdata;
	mafp_rxbyte_t           rxIn;
	mafp_match_t            matchOut;
	logic [63:0]            hashFilter;
	logic                   pauseActive;
	logic                   start;
	logic [47:0]            dest;
	logic [3:0]             gap;
	logic [31:0]            rdv;
	logic [31:0]            expv;
	logic [47:0]            rev;
	logic [3:0][47:0]       slotA;
	int                     cyc = 0;
	int                     t0;
	int                     nErrors;
	int                     checked;

	mafp_top #(.Q10_CYC(Q10)) mafp_top_i (.clk_sys(clk_sys),
		.reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.rxIn(rxIn), .matchOut(matchOut), .hashFilter(hashFilter),
		.pauseActive(pauseActive));
	mafp_link_partner mafp_link_partner_i (.clk_sys(clk_sys),
		.reset_n(reset_n), .start(start), .dest(dest), .gap(gap),
		.rxOut(rxIn), .busy());

	// free-running clock and cycle count for timed checks
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;

	// ***************************************************************
	// bus and frame tasks
	// ***************************************************************
	function automatic logic [7:0] ofs(input int i);
		logic [7:0] fix [5];
		fix = '{`MAFP_STATUS_OFS, `MAFP_CTRL_OFS, `MAFP_PAUSE_OFS,
			`MAFP_HASHLO_OFS, `MAFP_HASHHI_OFS};
		if (i < 5)
			return fix[i];
		return 8'(`MAFP_SA_BASE + ((i - 5) / 2) * `MAFP_SA_STEP
			+ ((i - 5) % 2) * `MAFP_SA_HI_OFS);
	endfunction : ofs

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		#1;
		d = regRdata;
	endtask : rd

	task automatic wait_until(input int t);
		while (cyc < t)
			@(posedge clk_sys);
	endtask : wait_until

	task automatic end_of_test;
		if (nErrors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	// one address through the partner, result pulse awaited with a bound
	task automatic send(input logic [47:0] d, input logic [3:0] g,
		input logic eh, input logic [1:0] es);
		int n;
		@(posedge clk_sys);
		dest  <= d;
		gap   <= g;
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		n = 0;
		while (n < 80 && matchOut.checked !== 1'b1)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 80)
		begin
			nErrors++;
			end_of_test();
		end
		`CHECK("hit", eh, matchOut.hit)
		if (eh)
			`CHECK("slot", es, matchOut.slot)
		`CHECK("mcast", d[0], matchOut.mcast)
	endtask : send

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial
	begin
		reset_n = 1'b0;
		regAddr = '0;
		regWdata = '0;
		regWrite = 1'b0;
		regRead = 1'b0;
		start = 1'b0;
		dest = '0;
		gap = '0;
		nErrors = 0;
		checked = 0;
		slotA = {48'h8000_0000_0002, 48'h5555_AAAA_0F0F,
			48'hFEDC_BA98_7654, 48'h0123_4567_89AB};
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		// every register reads zero after reset
		for (int i = 0; i < 13; i++)
		begin
			rd(ofs(i), rdv);
			`CHECK("reset", 32'h0, rdv)
		end
		// hash words, with an unmapped write that must not alias
		wr(`MAFP_HASHLO_OFS, 32'hDEAD_BEEF);
		wr(`MAFP_HASHHI_OFS, 32'h0123_4567);
		wr(8'hFC, 32'hFFFF_FFFF);
		rd(8'hFC, rdv);
		`CHECK("unmapped", 32'h0, rdv)
		rd(`MAFP_HASHLO_OFS, rdv);
		`CHECK("hashLo", 32'hDEAD_BEEF, rdv)
		rd(`MAFP_HASHHI_OFS, rdv);
		`CHECK("hashHi", 32'h0123_4567, rdv)
		`CHECK("hashFilter", 64'h0123_4567_DEAD_BEEF, hashFilter)
		// write strobe followed at once by a read strobe, no idle cycle
		@(posedge clk_sys);
		regAddr  <= `MAFP_HASHLO_OFS;
		regWdata <= 32'h1357_9BDF;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		regRead  <= 1'b1;
		@(posedge clk_sys);
		regRead  <= 1'b0;
		#1;
		`CHECK("hashLoB2B", 32'h1357_9BDF, regRdata)
		// slots: junk in the unused top half must read back as zero
		for (int i = 0; i < 4; i++)
		begin
			wr(ofs(5 + 2 * i), slotA[i][31:0]);
			wr(ofs(6 + 2 * i), {16'hA5A5, slotA[i][47:32]});
			rd(ofs(6 + 2 * i), rdv);
			expv = {16'h0, slotA[i][47:32]};
			`CHECK("slotHi", expv, rdv)
			rd(ofs(5 + 2 * i), rdv);
			`CHECK("slotLo", slotA[i][31:0], rdv)
		end
		// each slot hit with a different byte spacing
		for (int i = 0; i < 4; i++)
			send(slotA[i], 4'(i), 1'b1, 2'(i));
		send(slotA[0] ^ 48'h8000_0000_0000, 4'h0, 1'b0, 2'h0);
		rev = {<<8{slotA[1]}};
		send(rev, 4'h1, 1'b0, 2'h0);
		// countdown at the slow rate, upper half of the write dropped
		wr(`MAFP_PAUSE_OFS, 32'hFFFF_0003);
		t0 = cyc;
		rd(`MAFP_PAUSE_OFS, rdv);
		`CHECK("pause", 32'h3, rdv)
		`CHECK("pauseActive", 1'b1, pauseActive)
		wait_until(t0 + 31);
		rd(`MAFP_PAUSE_OFS, rdv);
		`CHECK("pause", 32'h2, rdv)
		wait_until(t0 + 51);
		rd(`MAFP_PAUSE_OFS, rdv);
		`CHECK("pause", 32'h1, rdv)
		rd(`MAFP_STATUS_OFS, rdv);
		`CHECK("flagEarly", 32'h0, rdv)
		wait_until(t0 + 71);
		rd(`MAFP_STATUS_OFS, rdv);
		`CHECK("flagSet", 32'h1, rdv)
		rd(`MAFP_STATUS_OFS, rdv);
		`CHECK("flagCleared", 32'h0, rdv)
		rd(`MAFP_PAUSE_OFS, rdv);
		`CHECK("pause", 32'h0, rdv)
		`CHECK("pauseActive", 1'b0, pauseActive)
		// loading zero is no countdown and raises nothing
		wr(`MAFP_PAUSE_OFS, 32'h0);
		repeat (5) @(posedge clk_sys);
		rd(`MAFP_STATUS_OFS, rdv);
		`CHECK("flagZeroLoad", 32'h0, rdv)
		// fast link: one quantum is 640 cycles
		wr(`MAFP_CTRL_OFS, 32'h1);
		wr(`MAFP_PAUSE_OFS, 32'h1);
		t0 = cyc;
		wait_until(t0 + 600);
		rd(`MAFP_PAUSE_OFS, rdv);
		`CHECK("pauseFast", 32'h1, rdv)
		wait_until(t0 + 660);
		rd(`MAFP_PAUSE_OFS, rdv);
		`CHECK("pauseFast", 32'h0, rdv)
		rd(`MAFP_STATUS_OFS, rdv);
		`CHECK("flagFast", 32'h1, rdv)
		end_of_test();
	end
endmodule : mafp_top_test
